/* File: common/s3rx_cfg.svh */
`ifndef S3RX_CFG_SVH
`define S3RX_CFG_SVH
// ************************************************************
// link widths and lanes
// ************************************************************
`define S3RX_DATA_W      32
`define S3RX_LANES       4
`define S3RX_LANE_W      8
`define S3RX_PORT_W      2
`define S3RX_ADDR_W      8
// ************************************************************
// word-modulo codes
// ************************************************************
`define S3RX_MOD_4B      2'h0
`define S3RX_MOD_3B      2'h1
`define S3RX_MOD_2B      2'h2
`define S3RX_MOD_1B      2'h3
`define S3RX_FULL_BYTES  3'h4
// ************************************************************
// reset values
// ************************************************************
`define S3RX_RST_DAT     32'h0000_0000
`define S3RX_RST_LANE    4'h0
`define S3RX_RST_PORT    2'h0
`endif

/* File: common/s3rx_pkg.sv */
`default_nettype none
`include "s3rx_cfg.svh"
package s3rx_pkg;
  typedef enum logic {
    S3RX_MULTI,
    S3RX_SINGLE
  } s3rx_mode_t;

  typedef struct packed {
    logic [`S3RX_DATA_W-1:0] dat;
    logic [`S3RX_LANES-1:0]  val;
    logic [`S3RX_LANES-1:0]  eop;
    logic [1:0]              mod;
    logic                    sx;
  } s3rx_link_t;

  typedef struct packed {
    s3rx_link_t              link;
    logic [`S3RX_PORT_W-1:0] cur_port;
    logic                    port_known;
    logic                    hold_full;
    logic [`S3RX_DATA_W-1:0] hold_dat;
    logic                    hold_eop;
    logic [1:0]              hold_mod;
    logic                    ready;
  } s3rx_dev_state_t;

  typedef struct packed {
    logic                    pkt_valid;
    logic [`S3RX_DATA_W-1:0] pkt_data;
    logic                    pkt_eop;
    logic [2:0]              pkt_nbytes;
    logic [`S3RX_PORT_W-1:0] pkt_port;
    logic                    port_known;
    logic [`S3RX_LANES-1:0]  lane_valid;
    logic [`S3RX_DATA_W-1:0] lane_data;
    logic [`S3RX_LANES-1:0]  lane_eop;
  } s3rx_host_state_t;
endpackage
`default_nettype wire

/* File: common/s3rx_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "s3rx_cfg.svh"
interface s3rx_link_if (
  input wire logic clk_sys_in
);
  logic [`S3RX_DATA_W-1:0] rdat;
  logic [`S3RX_LANES-1:0]  rval;
  logic [`S3RX_LANES-1:0]  reop;
  logic [1:0]              rmod;
  logic                    rsx;

  modport dev (
    output rdat,
    output rval,
    output reop,
    output rmod,
    output rsx
  );

  modport host (
    input rdat,
    input rval,
    input reop,
    input rmod,
    input rsx
  );
endinterface
`default_nettype wire

/* File: rtl/s3rx_dev.sv */
// Summary of operation
// [R1] multi-phy: modulo code gives valid byte count
// [R2] modulo stays 00 except last word
// [R3] 00=4, 01=3, 10=2, 11=1 bytes
// [R4] modulo meaningful in the end-of-packet cycle
// [R5] single-phy: modulo carries no meaning
// [R6] receiver trusts modulo only with valid
// [R7] start strobe marks in-band port address cycle
// [R8] address on bits 7:0 with valid low
// [R9] later words come from addressed fifo
// [R10] addresses 0 to 3 select ports
// [R11] receiver ignores start strobe without address cycle
// [R12] single-phy: receiver ignores start strobe
// [R13] single-phy: one end-of-packet per lane
// [R14] all qualifiers change on the system clock
`timescale 1ns/1ps
`default_nettype none
`include "s3rx_cfg.svh"
module s3rx_dev (
  input  wire logic                    clk_sys_in,
  input  wire logic                    rst_in,
  input  wire s3rx_pkg::s3rx_mode_t    mode_in,
  input  wire logic                    word_valid_in,
  input  wire logic [`S3RX_DATA_W-1:0] word_data_in,
  input  wire logic                    word_eop_in,
  input  wire logic [1:0]              word_mod_in,
  input  wire logic [`S3RX_PORT_W-1:0] word_port_in,
  output logic                         word_ready_out,
  input  wire logic [`S3RX_LANES-1:0]  lane_valid_in,
  input  wire logic [`S3RX_DATA_W-1:0] lane_data_in,
  input  wire logic [`S3RX_LANES-1:0]  lane_eop_in,
  s3rx_link_if.dev                     link
);
  import s3rx_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  s3rx_dev_state_t st;
  s3rx_dev_state_t next_st;

  // ************************************************************
  // mode
  // ************************************************************
  logic multi_mode;

  // mode is a level on this clock, so no synchroniser is needed
  assign multi_mode = (mode_in == S3RX_MULTI);

  // ************************************************************
  // offer decode
  // ************************************************************
  logic                    take_word;
  logic                    port_switch;
  logic [`S3RX_DATA_W-1:0] addr_word;
  logic [1:0]              offer_mod;
  logic [1:0]              held_mod;

  // ready is high only with nothing parked,
  // so a taken offer is never sent twice, and is lost only if reset or lane mode comes while it is parked
  assign take_word   = multi_mode && word_valid_in && st.ready;
  // after reset or lane mode the port is unknown and must be named again
  assign port_switch = !st.port_known || (word_port_in != st.cur_port); // [R9]
  // only the port bits are ever nonzero, so the address stays in 0 to 3
  assign addr_word   = {{(`S3RX_DATA_W - `S3RX_PORT_W){1'b0}}, word_port_in}; // [R10]
  // a stray code on a middle word must never reach the pins;
  // the held word is cleaned the same way
  assign offer_mod   = word_eop_in ? word_mod_in : `S3RX_MOD_4B; // [R2]
  assign held_mod    = st.hold_eop ? st.hold_mod : `S3RX_MOD_4B; // [R2]

  // ************************************************************
  // lane mode end marks
  // ************************************************************
  logic [`S3RX_LANES-1:0] lane_eop;

  // each lane carries its own end mark; an idle lane never shows one
  // data passes as is: the receiver looks at a lane only while it is valid
  genvar lane;
  for (lane = 0; lane < `S3RX_LANES; lane = lane + 1) begin : g_lane
    assign lane_eop[lane] = lane_valid_in[lane] & lane_eop_in[lane]; // [R13]
  end

  // ************************************************************
  // candidate link words
  // ************************************************************
  // each link word is built once here and the next-state logic only
  // picks one, which keeps pin values out of the branch logic
  s3rx_link_t idle_link;
  s3rx_link_t lane_link;
  s3rx_link_t addr_link;
  s3rx_link_t word_link;
  s3rx_link_t held_link;

  // idle link: nothing valid, modulo parked at full word
  assign idle_link = {
    `S3RX_RST_DAT,          // data
    `S3RX_RST_LANE,         // valid
    `S3RX_RST_LANE,         // end of packet
    `S3RX_MOD_4B,           // modulo [R2]
    1'b0                    // start
  };

  // lane mode: each lane is its own port, so no address and no modulo
  assign lane_link = {
    lane_data_in,           // data [R5]
    lane_valid_in,          // valid
    lane_eop,               // end of packet [R13]
    `S3RX_MOD_4B,           // modulo
    1'b0                    // start
  };

  // address cycle: valid stays low while the port number is on the data
  assign addr_link = {
    addr_word,              // data [R8] [R10]
    `S3RX_RST_LANE,         // valid [R8]
    `S3RX_RST_LANE,         // end of packet
    `S3RX_MOD_4B,           // modulo
    1'b1                    // start [R7]
  };

  // word straight from the offer; multi mode uses lane 0 only
  assign word_link = {
    word_data_in,           // data [R9]
    4'h1,                   // valid
    {3'h0, word_eop_in},    // end of packet
    offer_mod,              // modulo [R1] [R3] [R4]
    1'b0                    // start
  };

  // word parked behind its address cycle
  assign held_link = {
    st.hold_dat,            // data [R9]
    4'h1,                   // valid
    {3'h0, st.hold_eop},    // end of packet
    held_mod,               // modulo [R1] [R3] [R4]
    1'b0                    // start
  };

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_st      = st;
    next_st.link = idle_link;
    if (!multi_mode) begin
      // back in multi mode the port must be named again
      next_st.link       = lane_link; // [R5] [R13]
      next_st.hold_full  = 1'b0;
      next_st.port_known = 1'b0;
      next_st.ready      = 1'b0;
    end else if (st.hold_full) begin
      // word parked behind the address cycle goes out now
      next_st.link      = held_link; // [R9]
      next_st.hold_full = 1'b0;
      next_st.ready     = 1'b1;
    end else if (take_word && port_switch) begin
      // insert address cycle; costs one bubble per port switch
      next_st.link       = addr_link; // [R7] [R8]
      next_st.cur_port   = word_port_in;
      next_st.port_known = 1'b1;
      next_st.hold_full  = 1'b1;
      next_st.hold_dat   = word_data_in;
      next_st.hold_eop   = word_eop_in;
      next_st.hold_mod   = word_mod_in;
      next_st.ready      = 1'b0;
    end else begin
      next_st.ready = 1'b1;
      if (take_word) begin
        next_st.link = word_link; // [R9]
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // sync reset parks the link idle and forgets the port
  always_ff @(posedge clk_sys_in) begin // [R14]
    if (rst_in) begin
      st.link.dat   <= `S3RX_RST_DAT;
      st.link.val   <= `S3RX_RST_LANE;
      st.link.eop   <= `S3RX_RST_LANE;
      st.link.mod   <= `S3RX_MOD_4B;
      st.link.sx    <= 1'b0;
      st.cur_port   <= `S3RX_RST_PORT;
      st.port_known <= 1'b0;
      st.hold_full  <= 1'b0;
      st.hold_dat   <= `S3RX_RST_DAT;
      st.hold_eop   <= 1'b0;
      st.hold_mod   <= `S3RX_MOD_4B;
      st.ready      <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // every pin comes straight from the state register
  assign link.rdat      = st.link.dat;
  assign link.rval      = st.link.val;
  assign link.reop      = st.link.eop;
  assign link.rmod      = st.link.mod;
  assign link.rsx       = st.link.sx;
  assign word_ready_out = st.ready;
endmodule
`default_nettype wire

/* File: rtl/s3rx_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "s3rx_cfg.svh"
module s3rx_host (
  input  wire logic                    clk_sys_in,
  input  wire logic                    rst_in,
  input  wire s3rx_pkg::s3rx_mode_t    mode_in,
  s3rx_link_if.host                    link,
  output logic                         pkt_valid_out,
  output logic [`S3RX_DATA_W-1:0]      pkt_data_out,
  output logic                         pkt_eop_out,
  output logic [2:0]                   pkt_nbytes_out,
  output logic [`S3RX_PORT_W-1:0]      pkt_port_out,
  output logic [`S3RX_LANES-1:0]       lane_valid_out,
  output logic [`S3RX_DATA_W-1:0]      lane_data_out,
  output logic [`S3RX_LANES-1:0]       lane_eop_out
);
  import s3rx_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  s3rx_host_state_t st;
  s3rx_host_state_t next_st;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_st            = st;
    next_st.pkt_valid  = 1'b0;
    next_st.pkt_eop    = 1'b0;
    next_st.lane_valid = `S3RX_RST_LANE;
    next_st.lane_eop   = `S3RX_RST_LANE;
    if (mode_in == S3RX_SINGLE) begin
      // start strobe and modulo are not looked at here
      next_st.lane_valid = link.rval; // [R12] [R5]
      next_st.lane_data  = link.rdat;
      next_st.lane_eop   = link.rval & link.reop;
      next_st.port_known = 1'b0;
    end else begin
      // strobe counts only as an address cycle, lane 0 valid low
      if (link.rsx && !link.rval[0]) begin // [R11]
        // addresses above 3 name no port and are dropped
        if (link.rdat[`S3RX_ADDR_W-1:`S3RX_PORT_W] == '0) begin // [R10]
          next_st.pkt_port   = link.rdat[`S3RX_PORT_W-1:0]; // [R9]
          next_st.port_known = 1'b1;
        end
      end
      if (link.rval[0] && st.port_known) begin
        next_st.pkt_valid  = 1'b1;
        next_st.pkt_data   = link.rdat;
        next_st.pkt_eop    = link.reop[0];
        next_st.pkt_nbytes = `S3RX_FULL_BYTES;
        if (link.reop[0]) begin // [R4] [R6]
          next_st.pkt_nbytes = 3'(`S3RX_FULL_BYTES - {1'b0, link.rmod}); // [R3]
        end
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st.pkt_valid  <= 1'b0;
      st.pkt_data   <= `S3RX_RST_DAT;
      st.pkt_eop    <= 1'b0;
      st.pkt_nbytes <= `S3RX_FULL_BYTES;
      st.pkt_port   <= `S3RX_RST_PORT;
      st.port_known <= 1'b0;
      st.lane_valid <= `S3RX_RST_LANE;
      st.lane_data  <= `S3RX_RST_DAT;
      st.lane_eop   <= `S3RX_RST_LANE;
    end else begin
      st <= next_st;
    end
  end

  assign pkt_valid_out  = st.pkt_valid;
  assign pkt_data_out   = st.pkt_data;
  assign pkt_eop_out    = st.pkt_eop;
  assign pkt_nbytes_out = st.pkt_nbytes;
  assign pkt_port_out   = st.pkt_port;
  assign lane_valid_out = st.lane_valid;
  assign lane_data_out  = st.lane_data;
  assign lane_eop_out   = st.lane_eop;
endmodule
`default_nettype wire

/* File: verif/s3rx_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "s3rx_cfg.svh"
module s3rx_asserts (
  input wire logic                    clk_sys_in,
  input wire logic                    rst_in,
  input wire logic [`S3RX_DATA_W-1:0] rdat,
  input wire logic [`S3RX_LANES-1:0]  rval,
  input wire logic [`S3RX_LANES-1:0]  reop,
  input wire logic [1:0]              rmod,
  input wire logic                    rsx
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  // ****************************************
  // link properties
  // ****************************************
  sequence s_addr;
    rsx && rval == 4'h0;
  endsequence
  sequence s_word;
    rval[0] && !rsx;
  endsequence
  property p_mod_eop;
    rmod != 2'h0 |-> reop[0] && rval[0];
  endproperty
  property p_eop_vld;
    reop != 4'h0 |-> (reop & ~rval) == 4'h0;
  endproperty
  property p_sx_novld;
    rsx |-> rval == 4'h0;
  endproperty
  property p_sx_addr;
    rsx |-> rdat[31:2] == 30'h0;
  endproperty
  property p_addr_word;
    s_addr |=> s_word;
  endproperty
  property p_idle;
    rval == 4'h0 && !rsx |-> reop == 4'h0 && rmod == 2'h0;
  endproperty
  property p_lanes;
    rval[3:1] != 3'h0 |-> !rsx && rmod == 2'h0;
  endproperty
  property p_sx_once;
    rsx |-> !$past(rsx);
  endproperty
  a_mod_eop: assert property (p_mod_eop) else $error("modulo off last word");
  a_eop_vld: assert property (p_eop_vld) else $error("eop without valid");
  a_sx_novld: assert property (p_sx_novld) else $error("start with valid");
  a_sx_addr: assert property (p_sx_addr) else $error("address out of range");
  a_addr_word: assert property (p_addr_word) else $error("no word after address");
  a_idle: assert property (p_idle) else $error("idle qualifiers set");
  a_lanes: assert property (p_lanes) else $error("lane mode qualifiers");
  a_sx_once: assert property (p_sx_once) else $error("start held two cycles");
endmodule
`default_nettype wire

/* File: verif/s3rx_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module s3rx_tb_top;
  import s3rx_pkg::*;
  logic clk, rst, wv, we, rdy, pv, pe;
  logic [31:0] wd, ld, pd, lo_d;
  logic [1:0] wm, wp, pp;
  logic [3:0] lv, le, lo_v, lo_e;
  logic [2:0] pn;
  s3rx_mode_t md;
  logic [37:0] exp_q[$];
  int miscompares = 0;
  int checks = 0;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  s3rx_link_if link_if (.clk_sys_in(clk));
  s3rx_dev s3rx_dev_i (.clk_sys_in(clk), .rst_in(rst), .mode_in(md), .word_valid_in(wv),
    .word_data_in(wd), .word_eop_in(we), .word_mod_in(wm), .word_port_in(wp),
    .word_ready_out(rdy), .lane_valid_in(lv), .lane_data_in(ld), .lane_eop_in(le),
    .link(link_if));
  s3rx_host s3rx_host_i (.clk_sys_in(clk), .rst_in(rst), .mode_in(md), .link(link_if),
    .pkt_valid_out(pv), .pkt_data_out(pd), .pkt_eop_out(pe), .pkt_nbytes_out(pn),
    .pkt_port_out(pp), .lane_valid_out(lo_v), .lane_data_out(lo_d), .lane_eop_out(lo_e));
  s3rx_asserts s3rx_asserts_i (.clk_sys_in(clk), .rst_in(rst), .rdat(link_if.rdat),
    .rval(link_if.rval), .reop(link_if.reop), .rmod(link_if.rmod), .rsx(link_if.rsx));
  task automatic fail(string s);
    miscompares++;
    $display("CHECK FAILED %0t %s", $time, s);
  endtask
  task automatic cmp_w(logic [37:0] g, logic [37:0] e);
    checks++;
    if (g !== e) fail("word mismatch");
  endtask
  task automatic cmp_l(logic [39:0] g, logic [39:0] e);
    checks++;
    if (g !== e) fail("lane mismatch");
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // offer one word; returns one falling edge after the taking edge
  task automatic send(logic [31:0] d, logic e, logic [1:0] m, logic [1:0] p);
    int n;
    wv = 1'b1;
    wd = d;
    we = e;
    wm = m;
    wp = p;
    for (n = 0; n < 20 && rdy !== 1'b1; n++) @(negedge clk);
    if (n == 20) begin
      fail("ready timeout");
      wrap_up();
    end
    exp_q.push_back({d, e, 3'h4 - (e ? {1'b0, m} : 3'h0), p});
    @(negedge clk);
  endtask
  always @(negedge clk) begin
    if (pv === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected word");
      else cmp_w({pd, pe, pn, pp}, exp_q.pop_front());
    end
  end
  initial begin
    {wv, we, wd, wm, wp, lv, ld, le} = '0;
    md = S3RX_MULTI;
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    // every modulo code, each on its own port, so each packet forces a switch
    for (int m = 0; m < 4; m++) begin
      send(32'ha5a5_0000 + m, 1'b0, 2'h3, m[1:0]);
      send(32'h5a5a_0000 + m, 1'b1, m[1:0], m[1:0]);
    end
    wv = 1'b0;
    // let the last word reach the host before the mode changes
    repeat (2) @(negedge clk);
    md = S3RX_SINGLE;
    lv = 4'ha;
    ld = 32'h1122_3344;
    le = 4'hc;
    repeat (2) @(negedge clk);
    cmp_l({lo_v, lo_d, lo_e}, {4'ha, 32'h1122_3344, 4'h8});
    lv = 4'h0;
    ld = 32'h0;
    le = 4'h0;
    md = S3RX_MULTI;
    @(negedge clk);
    // lane mode forgot the port, so the same port needs a fresh address
    send(32'hdead_beef, 1'b1, 2'h2, 2'h3);
    wv = 1'b0;
    repeat (6) @(negedge clk);
    if (exp_q.size() != 0) fail("words lost");
    wrap_up();
  end
endmodule
`default_nettype wire
